/* File: logic/pfcs_top.sv */
// Behaviour
// RULE1: Bit 6 enables half-duplex backpressure generation
// RULE2: Bit 5 reports current duplex, 1 half
// RULE3: Bit 4 reports receive pause now active
// RULE4: Bit 3 reports transmit pause now active
// RULE5: Bit 2 enables pause detection when manual
// RULE6: Bit 1 enables pause generation when manual
// RULE7: Override clear, negotiation on: follow negotiation
// RULE8: Override clear, negotiation off: use bits
// RULE9: Override set: bits rule full duplex
// RULE10: Status bits show actually enabled flow control
// RULE11: Writes never touch PHY advertisement values
// RULE12: Straps and loader rewrite set defaults
// RULE13: Status reset values come from several straps; here the status bits reset to 0 and duplex status comes from port_in only
// RULE14: Bits 31 to 7 read zero
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module pfcs_top (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [11:0]           s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [11:0]           s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire pfcs_pkg::pfcs_strap_t strap_pins,
   input  wire pfcs_pkg::pfcs_strap_t loader_straps,
   input  wire logic                  loader_load,
   input  wire pfcs_pkg::pfcs_port_t  port_in,
   output pfcs_pkg::pfcs_fc_t         fc_out
);

   // ==========================================================
   // Strap pins into the clock domain
   logic [2:0]            strap_sync;
   pfcs_pkg::pfcs_strap_t strap_now;
   logic                  duplex_now;

   pfcs_sync #(
      .W (pfcs_pkg::STRAP_W)
   ) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (strap_pins),
      .sync_out (strap_sync)
   );

   assign strap_now = strap_sync;

   // ==========================================================
   // Setup register and strap load
   pfcs_pkg::pfcs_setup_t setup_reg;
   pfcs_pkg::pfcs_setup_t setup_next;
   logic [2:0]            settle_reg;
   logic [2:0]            settle_next;
   logic                  wr_hit;

   // ==========================================================
   // Write channel state
   logic [11:0] awaddr_reg;
   logic [11:0] awaddr_next;
   logic        aw_held_reg;
   logic        aw_held_next;
   logic [31:0] wdata_reg;
   logic [31:0] wdata_next;
   logic        wstrb0_reg;
   logic        wstrb0_next;
   logic        w_held_reg;
   logic        w_held_next;
   logic        bvalid_reg;
   logic        bvalid_next;
   logic [1:0]  bresp_reg;
   logic [1:0]  bresp_next;
   logic        do_write;

   // Handshake readies
   assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
   assign do_write      = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign wr_hit        = do_write & (awaddr_reg[11:2] == pfcs_pkg::FC_SETUP_OFFSET[11:2]);

   // Next values of the write channel
   always_comb begin
      awaddr_next  = awaddr_reg;
      aw_held_next = aw_held_reg;
      wdata_next   = wdata_reg;
      wstrb0_next  = wstrb0_reg;
      w_held_next  = w_held_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         awaddr_next  = s_axi_awaddr;
         aw_held_next = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wdata_next  = s_axi_wdata;
         wstrb0_next = s_axi_wstrb[0];
         w_held_next = 1'b1;
      end
      if (do_write) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_hit ? pfcs_pkg::RESP_OKAY : pfcs_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
   end

   // Registers of the write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_reg  <= 12'h000;
         aw_held_reg <= 1'b0;
         wdata_reg   <= 32'h0000_0000;
         wstrb0_reg  <= 1'b0;
         w_held_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= pfcs_pkg::RESP_OKAY;
      end else begin
         awaddr_reg  <= awaddr_next;
         aw_held_reg <= aw_held_next;
         wdata_reg   <= wdata_next;
         wstrb0_reg  <= wstrb0_next;
         w_held_reg  <= w_held_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // Next values of the setup fields; loader beats software, only local bits change
   always_comb begin
      setup_next  = setup_reg;
      settle_next = settle_reg;
      if (settle_reg != 3'h0) begin
         settle_next = settle_reg - 3'h1;
         if (settle_reg == 3'h1) begin
            setup_next.port2_backpressure_on    = strap_now.port2_backpressure_pinopt; // RULE12
            setup_next.port2_rx_pause_allow     = strap_now.port2_fullduplex_pause_pinopt; // RULE12
            setup_next.port2_tx_pause_allow     = strap_now.port2_fullduplex_pause_pinopt; // RULE12
            setup_next.port2_fc_override_select = strap_now.port2_override_pinopt; // RULE12
         end
      end else if (loader_load) begin
         setup_next.port2_backpressure_on    = loader_straps.port2_backpressure_pinopt; // RULE12
         setup_next.port2_rx_pause_allow     = loader_straps.port2_fullduplex_pause_pinopt; // RULE12
         setup_next.port2_tx_pause_allow     = loader_straps.port2_fullduplex_pause_pinopt; // RULE12
         setup_next.port2_fc_override_select = loader_straps.port2_override_pinopt; // RULE12
      end else if (wr_hit && wstrb0_reg) begin
         // Only the low writable bits are kept; no path leads to the PHY
         setup_next.port2_backpressure_on    = wdata_reg[pfcs_pkg::BACKPRESSURE_ON_BIT]; // RULE1 RULE11
         setup_next.port2_rx_pause_allow     = wdata_reg[pfcs_pkg::RX_PAUSE_ALLOW_BIT]; // RULE5
         setup_next.port2_tx_pause_allow     = wdata_reg[pfcs_pkg::TX_PAUSE_ALLOW_BIT]; // RULE6
         setup_next.port2_fc_override_select = wdata_reg[pfcs_pkg::OVERRIDE_BIT]; // RULE9
      end
   end

   // Registers of the setup fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         setup_reg   <= {4{pfcs_pkg::FIELD_RESET}};
         settle_reg  <= pfcs_pkg::STRAP_SETTLE;
      end else begin
         setup_reg   <= setup_next;
         settle_reg  <= settle_next;
      end
   end

   // ==========================================================
   // Flow control resolution; status follows the setup fields (strap, loader or written) and port state
   pfcs_resolve u_resolve (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .setup      (setup_reg),
      .port_in    (port_in),
      .fc_out     (fc_out),
      .duplex_now (duplex_now)
   );

   // ==========================================================
   // Read channel
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [1:0]  rresp_reg;
   logic [1:0]  rresp_next;
   logic        rvalid_reg;
   logic        rvalid_next;
   logic [31:0] reg_view;

   assign s_axi_arready = ~rvalid_reg;

   // Read view with current state bits and zero reserved bits
   always_comb begin
      reg_view = 32'h0000_0000; // RULE14
      reg_view[pfcs_pkg::BACKPRESSURE_ON_BIT] = setup_reg.port2_backpressure_on;
      reg_view[pfcs_pkg::DUPLEX_NOW_BIT]      = duplex_now; // RULE2 RULE13
      reg_view[pfcs_pkg::RX_PAUSE_NOW_BIT]    = fc_out.rx_pause_en; // RULE3 RULE10
      reg_view[pfcs_pkg::TX_PAUSE_NOW_BIT]    = fc_out.tx_pause_en; // RULE4 RULE10
      reg_view[pfcs_pkg::RX_PAUSE_ALLOW_BIT]  = setup_reg.port2_rx_pause_allow;
      reg_view[pfcs_pkg::TX_PAUSE_ALLOW_BIT]  = setup_reg.port2_tx_pause_allow;
      reg_view[pfcs_pkg::OVERRIDE_BIT]        = setup_reg.port2_fc_override_select;
   end

   // Next values of the read channel
   always_comb begin
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      rvalid_next = rvalid_reg;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         if (s_axi_araddr[11:2] == pfcs_pkg::FC_SETUP_OFFSET[11:2]) begin
            rdata_next = reg_view;
            rresp_next = pfcs_pkg::RESP_OKAY;
         end else begin
            rdata_next = 32'h0000_0000;
            rresp_next = pfcs_pkg::RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   // Registers of the read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= pfcs_pkg::RESP_OKAY;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rresp_reg  <= rresp_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;
   assign s_axi_rvalid = rvalid_reg;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_backpressure;
      $past(aresetn) |->
         fc_out.backpressure_en == $past(setup_reg.port2_backpressure_on & port_in.duplex_half);
   endproperty
   a_backpressure: assert property (p_backpressure) // RULE1
      else $error("backpressure enable wrong");

   property p_duplex_now;
      $past(aresetn) |-> duplex_now == $past(port_in.duplex_half);
   endproperty
   a_duplex_now: assert property (p_duplex_now) // RULE2
      else $error("duplex status wrong");

   property p_status_read;
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == pfcs_pkg::FC_SETUP_OFFSET) |=>
         (s_axi_rdata[4:3] == {$past(fc_out.rx_pause_en), $past(fc_out.tx_pause_en)});
   endproperty
   a_status_read: assert property (p_status_read) // RULE3 RULE4 RULE10
      else $error("current pause status read wrong");

   property p_manual;
      (!port_in.duplex_half && (setup_reg.port2_fc_override_select || !port_in.an_enable)) |=>
         (fc_out.rx_pause_en == $past(setup_reg.port2_rx_pause_allow)) &&
         (fc_out.tx_pause_en == $past(setup_reg.port2_tx_pause_allow));
   endproperty
   a_manual: assert property (p_manual) // RULE5 RULE6 RULE8 RULE9
      else $error("manual pause enables not applied");

   property p_auto;
      (!port_in.duplex_half && !setup_reg.port2_fc_override_select && port_in.an_enable) |=>
         (fc_out.rx_pause_en == $past(port_in.an_rx_pause)) &&
         (fc_out.tx_pause_en == $past(port_in.an_tx_pause));
   endproperty
   a_auto: assert property (p_auto) // RULE7
      else $error("negotiated pause not followed");

   property p_loader;
      (loader_load && settle_reg == 3'h0) |=>
         setup_reg.port2_fc_override_select == $past(loader_straps.port2_override_pinopt) &&
         setup_reg.port2_rx_pause_allow == $past(loader_straps.port2_fullduplex_pause_pinopt);
   endproperty
   a_loader: assert property (p_loader) // RULE12
      else $error("loader rewrite not taken");

   property p_reserved;
      s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0;
   endproperty
   a_reserved: assert property (p_reserved) // RULE14
      else $error("reserved bits not zero");

   property p_bresp_hold;
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bresp_hold: assert property (p_bresp_hold)
      else $error("write response dropped");

   property p_write_answer;
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("write response late");

   c_manual_write: cover property (wr_hit && wstrb0_reg && wdata_reg[0]);
   c_auto_pause:   cover property (port_in.an_enable && fc_out.rx_pause_en);
   c_half_bp:      cover property (fc_out.backpressure_en);
   c_unmapped:     cover property (s_axi_rvalid && s_axi_rresp == pfcs_pkg::RESP_SLVERR);

endmodule
`default_nettype wire

/* File: logic/pfcs_pkg.sv */
`default_nettype none
package pfcs_pkg;

   // ==========================================================
   // Register map
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] FC_SETUP_OFFSET = 12'h1a4;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ==========================================================
   // Field positions of port2_flow_control_setup
   localparam int unsigned BACKPRESSURE_ON_BIT = 6;
   localparam int unsigned DUPLEX_NOW_BIT      = 5;
   localparam int unsigned RX_PAUSE_NOW_BIT    = 4;
   localparam int unsigned TX_PAUSE_NOW_BIT    = 3;
   localparam int unsigned RX_PAUSE_ALLOW_BIT  = 2;
   localparam int unsigned TX_PAUSE_ALLOW_BIT  = 1;
   localparam int unsigned OVERRIDE_BIT        = 0;
   localparam int unsigned RESERVED_LSB        = 7;

   // ==========================================================
   // Values after reset and counts
   localparam logic       FIELD_RESET     = 1'b0;
   localparam logic [2:0] STRAP_SETTLE    = 3'h5; // Outlasts the three-stage strap synchroniser
   localparam int unsigned STRAP_W        = 3;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic port2_backpressure_pinopt;
      logic port2_fullduplex_pause_pinopt;
      logic port2_override_pinopt;
   } pfcs_strap_t;

   typedef struct packed {
      logic an_enable;
      logic duplex_half;
      logic an_rx_pause;
      logic an_tx_pause;
   } pfcs_port_t;

   typedef struct packed {
      logic port2_backpressure_on;
      logic port2_rx_pause_allow;
      logic port2_tx_pause_allow;
      logic port2_fc_override_select;
   } pfcs_setup_t;

   typedef struct packed {
      logic backpressure_en;
      logic rx_pause_en;
      logic tx_pause_en;
   } pfcs_fc_t;

endpackage
`default_nettype wire

/* File: logic/pfcs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pfcs_sync #(
   parameter int unsigned W = 3
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   // ==========================================================
   // Three stages per bit, output moves once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic [2:0] stage_reg;
         logic [2:0] stage_next;
         logic       hold_reg;
         logic       hold_next;

         // Next values
         always_comb begin
            stage_next = {stage_reg[1:0], async_in[i]};
            hold_next  = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : hold_reg;
         end

         // Registers
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               stage_reg <= 3'h0;
               hold_reg  <= 1'b0;
            end else begin
               stage_reg <= stage_next;
               hold_reg  <= hold_next;
            end
         end

         assign sync_out[i] = hold_reg;
      end
   endgenerate

endmodule
`default_nettype wire

/* File: logic/pfcs_resolve.sv */
`timescale 1ns/1ps
`default_nettype none
module pfcs_resolve (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire pfcs_pkg::pfcs_setup_t setup,
   input  wire pfcs_pkg::pfcs_port_t  port_in,
   output pfcs_pkg::pfcs_fc_t         fc_out,
   output logic                       duplex_now
);

   pfcs_pkg::pfcs_fc_t fc_reg;
   pfcs_pkg::pfcs_fc_t fc_next;
   logic               dup_reg;
   logic               dup_next;
   logic               use_manual;

   // ==========================================================
   // Select between written enables and negotiated result
   always_comb begin
      use_manual = setup.port2_fc_override_select | ~port_in.an_enable; // RULE7 RULE8 RULE9
      dup_next   = port_in.duplex_half; // RULE2
      fc_next.backpressure_en = setup.port2_backpressure_on & port_in.duplex_half; // RULE1
      if (port_in.duplex_half) begin
         // Pause frames have no meaning in half duplex
         fc_next.rx_pause_en = 1'b0;
         fc_next.tx_pause_en = 1'b0;
      end else if (use_manual) begin
         fc_next.rx_pause_en = setup.port2_rx_pause_allow; // RULE5 RULE9
         fc_next.tx_pause_en = setup.port2_tx_pause_allow; // RULE6 RULE9
      end else begin
         fc_next.rx_pause_en = port_in.an_rx_pause; // RULE7
         fc_next.tx_pause_en = port_in.an_tx_pause; // RULE7
      end
   end

   // Registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fc_reg  <= '0;
         dup_reg <= 1'b0;
      end else begin
         fc_reg  <= fc_next;
         dup_reg <= dup_next;
      end
   end

   assign fc_out     = fc_reg;
   assign duplex_now = dup_reg;

endmodule
`default_nettype wire

/* File: tb/tb_pfcs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pfcs_top;
   // ==========================================================
   // Signals
   logic                  aclk = 1'b0;
   logic                  aresetn = 1'b0;
   logic [11:0]           s_axi_awaddr = 12'h000;
   logic                  s_axi_awvalid = 1'b0;
   logic                  s_axi_awready;
   logic [31:0]           s_axi_wdata = 32'h0000_0000;
   logic [3:0]            s_axi_wstrb = 4'h0;
   logic                  s_axi_wvalid = 1'b0;
   logic                  s_axi_wready;
   logic [1:0]            s_axi_bresp;
   logic                  s_axi_bvalid;
   logic                  s_axi_bready = 1'b0;
   logic [11:0]           s_axi_araddr = 12'h000;
   logic                  s_axi_arvalid = 1'b0;
   logic                  s_axi_arready;
   logic [31:0]           s_axi_rdata;
   logic [1:0]            s_axi_rresp;
   logic                  s_axi_rvalid;
   logic                  s_axi_rready = 1'b0;
   pfcs_pkg::pfcs_strap_t strap_pins = 3'h7;
   pfcs_pkg::pfcs_strap_t loader_straps = 3'h0;
   logic                  loader_load = 1'b0;
   pfcs_pkg::pfcs_port_t  port_in = 4'h8;
   pfcs_pkg::pfcs_fc_t    fc_out;
   int                    error_cnt = 0;
   int                    samples_checked = 0;
   int                    cycle_cnt = 0;
   logic [31:0]           rd;
   logic [1:0]            rsp;

   typedef struct packed {
      logic [31:0] w;
      logic [3:0]  p;
      logic [31:0] e;
   } pfcs_row_t;

   // Write data and port state beside the register image they give; the first row sets reserved bits
   pfcs_row_t rows [6] = '{'{32'hffff_ff86, 4'h9, 32'h0000_000e},
                          '{32'h0000_0006, 4'h2, 32'h0000_001e},
                          '{32'h0000_0005, 4'hb, 32'h0000_0015},
                          '{32'h0000_0047, 4'hf, 32'h0000_0067},
                          '{32'h0000_003a, 4'h0, 32'h0000_000a},
                          '{32'h0000_0000, 4'h4, 32'h0000_0020}};

   pfcs_top i_pfcs_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .strap_pins(strap_pins),
      .loader_straps(loader_straps), .loader_load(loader_load), .port_in(port_in),
      .fc_out(fc_out));

   // ==========================================================
   // Clock and watchdog
   always #12.5 aclk = ~aclk;

   always @(posedge aclk) begin
      cycle_cnt <= cycle_cnt + 1;
      if (cycle_cnt == 4000) begin
         error_cnt = error_cnt + 1;
         tally_and_finish();
      end
   end

   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Register image expected from the written fields and the port state
   function automatic logic [31:0] exp_reg(input logic [31:0] w, input logic [3:0] p);
      logic half;
      logic man;
      logic rx;
      logic tx;
      half = p[2];
      man = w[0] | ~p[3];
      rx = ~half & (man ? w[2] : p[1]);
      tx = ~half & (man ? w[1] : p[0]);
      exp_reg = {25'h0, w[6], half, rx, tx, w[2], w[1], w[0]};
   endfunction

   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
      logic aw_done;
      logic w_done;
      logic b_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      b_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b_done) begin
         @(posedge aclk);
         if (!aw_done && s_axi_awready) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid) begin
            b_done = 1'b1;
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_done;
      logic r_done;
      ar_done = 1'b0;
      r_done = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r_done) begin
         @(posedge aclk);
         if (!ar_done && s_axi_arready) begin
            ar_done = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid) begin
            r_done = 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
   endtask

   task automatic reset_dut();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge aclk);
      check({27'h0, s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid},
            32'h1c);
      check({29'h0, fc_out}, 32'h0);
      @(posedge aclk);
      aresetn <= 1'b1;
      // Read before the strap load sees cleared fields
      axi_read(pfcs_pkg::FC_SETUP_OFFSET, rd, rsp);
      check(rd, 32'h0);
      repeat (8) @(posedge aclk);
      axi_read(pfcs_pkg::FC_SETUP_OFFSET, rd, rsp);
      check(rd, exp_reg(32'h7f, 4'h8));
      check({29'h0, fc_out}, 32'h3);
      // Ordinary cases
      for (int i = 0; i < 6; i++) begin
         port_in <= rows[i].p;
         axi_write(pfcs_pkg::FC_SETUP_OFFSET, rows[i].w, 4'hf, rsp);
         check({30'h0, rsp}, {30'h0, pfcs_pkg::RESP_OKAY});
         repeat (2) @(posedge aclk);
         check({29'h0, fc_out},
               {29'h0, rows[i].e[6] & rows[i].e[5], rows[i].e[4], rows[i].e[3]});
         axi_read(pfcs_pkg::FC_SETUP_OFFSET, rd, rsp);
         check(rd, rows[i].e);
      end
      // Byte lane zero disabled leaves the fields alone
      axi_write(pfcs_pkg::FC_SETUP_OFFSET, 32'h0000_007f, 4'he, rsp);
      check({30'h0, rsp}, {30'h0, pfcs_pkg::RESP_OKAY});
      axi_read(pfcs_pkg::FC_SETUP_OFFSET, rd, rsp);
      check(rd, exp_reg(32'h0, 4'h4));
      // Unmapped neighbours answer with an error and change nothing
      axi_write(12'h1a0, 32'h0000_0047, 4'hf, rsp);
      check({30'h0, rsp}, {30'h0, pfcs_pkg::RESP_SLVERR});
      axi_read(12'h1a8, rd, rsp);
      check({rd[31:2], rsp}, {30'h0, pfcs_pkg::RESP_SLVERR});
      axi_read(pfcs_pkg::FC_SETUP_OFFSET, rd, rsp);
      check(rd, exp_reg(32'h0, 4'h4));
      // Loader rewrite of the strap values
      port_in <= 4'h8;
      loader_straps <= 3'h5;
      @(posedge aclk);
      loader_load <= 1'b1;
      @(posedge aclk);
      loader_load <= 1'b0;
      repeat (3) @(posedge aclk);
      axi_read(pfcs_pkg::FC_SETUP_OFFSET, rd, rsp);
      check(rd, exp_reg(32'h41, 4'h8));
      // Second reset with other strap levels
      strap_pins <= 3'h2;
      port_in <= 4'h9;
      repeat (4) @(posedge aclk);
      reset_dut();
      repeat (10) @(posedge aclk);
      axi_read(pfcs_pkg::FC_SETUP_OFFSET, rd, rsp);
      check(rd, exp_reg(32'h06, 4'h9));
      check({29'h0, fc_out}, 32'h1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
